// File: design/lcd_defines.svh
// Constants for the segment display controller: field positions, reset values, timing.
// Assumes inclusion by its bare name from design files only.
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH
`define LCD_MEM_BYTES 16
`define LCD_SEGS 32
`define LCD_COMS 4
`define LCD_DEDICATED_SEGS 8
`define LCD_CTRL_RESET 8'h00
`define LCD_EN_BIT 7
`define LCD_DUTY_MSB 3
`define LCD_DUTY_LSB 2
`define LCD_RATE_MSB 1
`define LCD_RATE_LSB 0
`define LCD_SEL_RESET 8'h00
`define LCD_BASE_DIV_LOG2 10
`endif

// File: design/lcd_pkg.sv
// Types shared by the segment display controller files.
// Assumes lcd_defines.svh supplies the numeric constants.
package lcd_pkg;
  typedef enum logic [1:0] {
    DUTY_QUARTER = 2'h0,
    DUTY_THIRD = 2'h1,
    DUTY_HALF = 2'h2,
    DUTY_STATIC = 2'h3
  } duty_t;
  typedef struct packed {
    logic en;
    logic boost;
    logic [1:0] boostRate;
    duty_t duty;
    logic [1:0] frameRate;
  } ctrl_t;
  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [7:0] data;
  } memwr_t;
endpackage : lcd_pkg

// File: design/lcd_phase_gen.sv
// Common phase divider: emits a one-cycle step pulse and the active common index.
// Assumes one clock; the rate selection comes from the control register.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_defines.svh"
module lcd_phase_gen #(
  parameter int BASE_LOG2 = `LCD_BASE_DIV_LOG2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Setup
  input wire logic [1:0] frameRate,
  input wire lcd_pkg::duty_t duty,
  // Phase
  output logic [1:0] comIdx,
  output logic step
);
  logic [BASE_LOG2+3:0] divCnt_r, divCnt_nxt;
  logic [1:0] comIdx_r, comIdx_nxt;
  logic step_r, step_nxt;
  logic [1:0] lastIdx;
  logic [BASE_LOG2+3:0] limit;
  always_comb begin
    case (duty)
      lcd_pkg::DUTY_QUARTER: lastIdx = 2'h3;
      lcd_pkg::DUTY_THIRD: lastIdx = 2'h2;
      lcd_pkg::DUTY_HALF: lastIdx = 2'h1;
      default: lastIdx = 2'h0;
    endcase
    // Slower rate codes divide further, by powers of two.
    limit = (BASE_LOG2+4)'((1 << (BASE_LOG2 + 3 - int'(frameRate))) - 1);
    step_nxt = 1'b0;
    divCnt_nxt = divCnt_r + (BASE_LOG2+4)'(1);
    comIdx_nxt = comIdx_r;
    if (divCnt_r >= limit) begin
      divCnt_nxt = '0;
      step_nxt = 1'b1;
      comIdx_nxt = (comIdx_r >= lastIdx) ? 2'h0 : comIdx_r + 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_r <= '0;
      comIdx_r <= 2'h0;
      step_r <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      comIdx_r <= comIdx_nxt;
      step_r <= step_nxt;
    end
  end
  assign comIdx = comIdx_r;
  assign step = step_r;
endmodule : lcd_phase_gen
`default_nettype wire

// File: design/lcd_segment_display_control.sv
// Segment display controller: display memory, control state, segment and common drive.
// Assumes the CPU writes control and memory synchronously on clk; pins are resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_defines.svh"
// Contract
// R01 - Nibble bits map commons; unused bits ignored
// R02 - Display enable zero blanks the panel
// R03 - Blanking drives all segments, commons low
// R04 - Stop mode entry clears display enable
// R05 - Software re-enables display after stop
// R06 - Reset holds dedicated segments, commons low
// R07 - Reset floats shared segment pins
// R08 - Software sets control, then port selects
// R09 - Software loads memory before enabling display
// R10 - Hardware scans sixteen memory bytes autonomously
// R11 - Bit one lights pixel, zero darkens
module lcd_segment_display_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control register write
  input wire logic ctrlWe,
  input wire logic [7:0] ctrlWdata,
  // Port segment-select writes
  input wire logic port1SelWe,
  input wire logic port5SelWe,
  input wire logic port7SelWe,
  input wire logic [7:0] selWdata,
  // Display memory write
  input wire lcd_pkg::memwr_t memWr,
  // Stop mode entry, one-cycle pulse
  input wire logic stopEntry,
  // Status
  output logic displayEnable,
  output logic [7:0] ctrlRead,
  // Electrodes
  output logic [`LCD_SEGS-1:0] segOut,
  output logic [`LCD_SEGS-1:0] segOe,
  output logic [`LCD_COMS-1:0] comOut,
  output logic [`LCD_COMS-1:0] comActive
);
  lcd_pkg::ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] sel1_r, sel1_nxt, sel5_r, sel5_nxt, sel7_r, sel7_nxt;
  logic [7:0] mem_r [`LCD_MEM_BYTES];
  logic [7:0] mem_nxt [`LCD_MEM_BYTES];
  logic [`LCD_SEGS-1:0] seg_r, seg_nxt, segOe_r, segOe_nxt;
  logic [`LCD_COMS-1:0] com_r, com_nxt, comAct_r, comAct_nxt;
  logic [1:0] comIdx;
  logic step;
  logic [`LCD_SEGS-`LCD_DEDICATED_SEGS-1:0] sharedSel;
  logic phaseRst_n;

  // ----------------------------------------
  // Common phase source
  // ----------------------------------------
  // R01 scan restarts at common0
  // The divider is held while the panel is blanked, so every enable shows common 0 first.
  // A lower duty then never starts on a common that it does not use.
  assign phaseRst_n = rst_n & ctrl_r.en;
  lcd_phase_gen #(.BASE_LOG2(`LCD_BASE_DIV_LOG2)) u_phase (
    .clk(clk),
    .rst_n(phaseRst_n),
    .frameRate(ctrl_r.frameRate),
    .duty(ctrl_r.duty),
    .comIdx(comIdx),
    .step(step)
  );

  // Returns the pixel bit for a segment on the active common.
  function automatic logic pixelBit(input logic [7:0] b, input int s, input logic [1:0] c);
    logic [3:0] nib;
    nib = s[0] ? b[7:4] : b[3:0];
    return nib[c];
  endfunction : pixelBit

  // ----------------------------------------
  // Control and memory next state
  // ----------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrlWe) begin
      ctrl_nxt = lcd_pkg::ctrl_t'(ctrlWdata);
    end
    // R04 stop clears enable
    if (stopEntry) begin
      ctrl_nxt.en = 1'b0;
    end
    sel1_nxt = port1SelWe ? selWdata : sel1_r;
    sel5_nxt = port5SelWe ? selWdata : sel5_r;
    sel7_nxt = port7SelWe ? selWdata : sel7_r;
    for (int i = 0; i < `LCD_MEM_BYTES; i++) begin
      mem_nxt[i] = (memWr.we && memWr.addr == 4'(i)) ? memWr.data : mem_r[i];
    end
  end

  // ----------------------------------------
  // Electrode drive next state
  // ----------------------------------------
  assign sharedSel = {sel7_r, sel5_r, sel1_r};
  always_comb begin
    seg_nxt = seg_r;
    com_nxt = com_r;
    comAct_nxt = comAct_r;
    segOe_nxt = {sharedSel, {`LCD_DEDICATED_SEGS{1'b1}}};
    if (!ctrl_r.en) begin
      // R02 blank when disabled
      // R03 ground all electrodes
      seg_nxt = '0;
      com_nxt = '0;
      comAct_nxt = '0;
    end else if (step || comAct_r == '0) begin
      // R10 autonomous memory scan
      // R01 nibble to common map
      // R11 one lights pixel
      for (int s = 0; s < `LCD_SEGS; s++) begin
        seg_nxt[s] = pixelBit(mem_r[s/2], s, comIdx);
      end
      comAct_nxt = 4'(1) << comIdx;
      com_nxt = comAct_nxt;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= lcd_pkg::ctrl_t'(`LCD_CTRL_RESET);
      sel1_r <= `LCD_SEL_RESET;
      sel5_r <= `LCD_SEL_RESET;
      sel7_r <= `LCD_SEL_RESET;
      // R06 reset drives low
      seg_r <= '0;
      com_r <= '0;
      comAct_r <= '0;
      // R07 shared pins float
      segOe_r <= {{(`LCD_SEGS-`LCD_DEDICATED_SEGS){1'b0}}, {`LCD_DEDICATED_SEGS{1'b1}}};
    end else begin
      ctrl_r <= ctrl_nxt;
      sel1_r <= sel1_nxt;
      sel5_r <= sel5_nxt;
      sel7_r <= sel7_nxt;
      seg_r <= seg_nxt;
      com_r <= com_nxt;
      comAct_r <= comAct_nxt;
      segOe_r <= segOe_nxt;
    end
  end
  always_ff @(posedge clk) begin
    for (int i = 0; i < `LCD_MEM_BYTES; i++) begin
      mem_r[i] <= mem_nxt[i];
    end
  end

  assign displayEnable = ctrl_r.en;
  assign ctrlRead = ctrl_r;
  assign segOut = seg_r;
  assign segOe = segOe_r;
  assign comOut = com_r;
  assign comActive = comAct_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_stop_clears;
    @(posedge clk) disable iff (!rst_n) stopEntry |=> !displayEnable;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("enable kept after stop"); // R04
  property p_blank_ground;
    @(posedge clk) disable iff (!rst_n) !displayEnable |=> (segOut == '0 && comOut == '0);
  endproperty
  a_blank_ground: assert property (p_blank_ground) else $error("drive while blanked"); // R02
  property p_blank_hold;
    @(posedge clk) disable iff (!rst_n)
      (!displayEnable && !ctrlWe) [*2] |-> (comActive == '0 && segOut == '0);
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("electrodes not at ground"); // R03
  property p_reset_low;
    @(posedge clk) !rst_n |=> (segOut == '0 && comOut == '0 && segOe[7:0] == 8'hFF);
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("reset drive not low"); // R06
  property p_reset_float;
    @(posedge clk) !rst_n |=> segOe[31:8] == 24'h00_0000;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("shared pins driven in reset"); // R07
  property p_one_common;
    @(posedge clk) disable iff (!rst_n) displayEnable |=> $onehot0(comOut);
  endproperty
  a_one_common: assert property (p_one_common) else $error("several commons active"); // R01
  property p_static_com0;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_r.duty == lcd_pkg::DUTY_STATIC && comIdx == 2'h0 && ctrl_r.en) [*3]
      |-> comOut[3:1] == 3'h0;
  endproperty
  a_static_com0: assert property (p_static_com0) else $error("unused common driven"); // R01
  property p_pixel;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_r.en && step && !stopEntry && !ctrlWe) |=>
      segOut[0] == mem_r[0][$past(comIdx)] || $past(memWr.we);
  endproperty
  a_pixel: assert property (p_pixel) else $error("pixel not from memory"); // R11
  property p_pixel_high;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_r.en && step && !stopEntry && !ctrlWe) |=>
      segOut[1] == mem_r[0][4 + $past(comIdx)] || $past(memWr.we);
  endproperty
  a_pixel_high: assert property (p_pixel_high) else $error("high nibble not mapped"); // R01
  property p_enable_com0;
    @(posedge clk) disable iff (!rst_n) $rose(displayEnable) |=> comOut == 4'h1;
  endproperty
  a_enable_com0: assert property (p_enable_com0) else $error("scan not from common 0"); // R01
  property p_mem_write;
    @(posedge clk) disable iff (!rst_n) memWr.we |=> mem_r[$past(memWr.addr)] == $past(memWr.data);
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("display memory write lost"); // R10
  c_enable: cover property (@(posedge clk) disable iff (!rst_n) $rose(displayEnable));
  c_stop: cover property (@(posedge clk) disable iff (!rst_n) displayEnable && stopEntry);
  c_scan: cover property (@(posedge clk) disable iff (!rst_n) comOut == 4'h8);
  c_static: cover property (@(posedge clk) disable iff (!rst_n)
    displayEnable && ctrl_r.duty == lcd_pkg::DUTY_STATIC);
  c_half: cover property (@(posedge clk) disable iff (!rst_n)
    comOut == 4'h2 && ctrl_r.duty == lcd_pkg::DUTY_HALF);
endmodule : lcd_segment_display_control
`default_nettype wire

// File: sim/lcd_panel_model.sv
// Panel model: latches lit pixels from the segment and common levels.
// Assumes one-hot common levels and segment level one meaning pixel on.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  // Clock
  input wire logic clk,
  // Electrodes
  input wire logic [31:0] segOut,
  input wire logic [31:0] segOe,
  input wire logic [3:0] comOut,
  // Pixels, common c at bits c*32 and up
  output logic [127:0] pixelOn
);
  always_ff @(posedge clk) begin
    for (int c = 0; c < 4; c++) begin
      if (comOut == 4'h0) pixelOn[c*32+:32] <= 32'h0000_0000;
      else if (comOut[c]) pixelOn[c*32+:32] <= segOut & segOe;
    end
  end
endmodule : lcd_panel_model
`default_nettype wire

// File: sim/lcd_segment_display_control_tb.sv
// Bench for the segment display controller with a panel model.
// Assumes step period of 1024 cycles at frame rate 3.
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_display_control_tb;
  typedef struct packed {logic [3:0] com; logic [31:0] seg;} note_t;
  logic clk = 0, rst_n = 0, ctrlWe = 0, stopEntry = 0, displayEnable;
  logic port1SelWe = 0, port5SelWe = 0, port7SelWe = 0;
  logic [7:0] ctrlWdata = 0, selWdata = 0, ctrlRead;
  lcd_pkg::memwr_t memWr = '0;
  logic [31:0] segOut, segOe;
  logic [3:0] comOut, comActive, prevCom = 4'h0;
  logic [127:0] pixelOn;
  logic [7:0] mem [16];
  note_t notes[$];
  int n_mismatch = 0, total_checks = 0;
  always #2 clk = ~clk;
  lcd_segment_display_control DUT (.clk(clk), .rst_n(rst_n), .ctrlWe(ctrlWe),
    .ctrlWdata(ctrlWdata), .port1SelWe(port1SelWe), .port5SelWe(port5SelWe),
    .port7SelWe(port7SelWe), .selWdata(selWdata), .memWr(memWr), .stopEntry(stopEntry),
    .displayEnable(displayEnable), .ctrlRead(ctrlRead), .segOut(segOut), .segOe(segOe),
    .comOut(comOut), .comActive(comActive));
  lcd_panel_model panel (.clk(clk), .segOut(segOut), .segOe(segOe), .comOut(comOut),
    .pixelOn(pixelOn));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task wr_ctrl(input logic [7:0] d);
    ctrlWdata = d;
    ctrlWe = 1;
    cyc(1);
    ctrlWe = 0;
  endtask : wr_ctrl
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // Monitor and stimulus
  // ----------------------------------------
  // Each change of the commons pops the oldest note.
  always @(negedge clk) begin
    note_t n;
    if (rst_n && comOut !== prevCom) begin
      prevCom = comOut;
      if (notes.size() > 0) begin
        n = notes.pop_front();
        chk({28'h0, comOut}, {28'h0, n.com});
        chk(segOut, n.seg);
      end else begin
        n_mismatch++;
        $display("ERROR %0t: common changed with nothing expected", $time);
      end
    end
  end
  initial begin
    #80000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    int n;
    logic [31:0] s;
    void'($urandom(42));
    cyc(16);
    chk(segOut, 32'h0000_0000);
    chk({28'h0, comOut}, 32'h0000_0000);
    chk(segOe, 32'h0000_00FF);
    rst_n = 1;
    wr_ctrl(8'h03);
    selWdata = 8'hFF;
    {port1SelWe, port5SelWe, port7SelWe} = 3'h7;
    cyc(1);
    {port1SelWe, port5SelWe, port7SelWe} = 3'h0;
    cyc(2);
    chk(segOe, 32'hFFFF_FFFF);
    for (int d = 0; d < 4; d++) begin
      n = 4 - d;
      for (int k = 0; k < 16; k++) begin
        mem[k] = 8'($urandom);
        memWr = '{we: 1'b1, addr: 4'(k), data: mem[k]};
        cyc(1);
      end
      memWr.we = 1'b0;
      for (int c = 0; c < n; c++) begin
        for (int k = 0; k < 16; k++) begin
          s[2*k] = mem[k][c];
          s[2*k+1] = mem[k][4+c];
        end
        notes.push_back({4'h1 << c, s});
      end
      wr_ctrl({1'b1, 3'h0, 2'(d), 2'h3});
      for (int t = 0; t < (n + 1) * 1024 && notes.size() > 0; t++) cyc(1);
      chk(32'(notes.size()), 32'h0000_0000);
      chk(pixelOn[(n-1)*32+:32], s);
      notes.push_back('0);
      if (d % 2 == 1) wr_ctrl({4'h0, 2'(d), 2'h3});
      else begin
        stopEntry = 1;
        cyc(1);
        stopEntry = 0;
      end
      cyc(4);
      chk(32'(notes.size()), 32'h0000_0000);
      chk({31'h0, displayEnable}, 32'h0000_0000);
      chk({24'h0, ctrlRead}, {24'h0, 4'h0, 2'(d), 2'h3});
      chk({31'h0, |pixelOn}, 32'h0000_0000);
    end
    wrap_up;
  end
endmodule : lcd_segment_display_control_tb
`default_nettype wire
